// >>> hdl/mcr_pkg.sv
// modem-control block constants: register map, bit positions, reset values
// assumes a 32-bit apb slave with byte addresses in paddr[7:0]
package modem_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] MODEM_CONTROL_OFFSET = 8'h10;
	localparam logic [7:0] MODEM_STATUS_OFFSET = 8'h18;

	// ----------------------------------------
	// modem_control fields
	// ----------------------------------------
	localparam int RTS_BIT = 1;
	localparam int LOOPBACK_BIT = 4;
	localparam int AUTO_FLOW_BIT = 5;
	localparam int IR_MODE_BIT = 6;
	localparam logic [15:0] MODEM_CONTROL_RESET = 16'h0000;
	localparam logic [15:0] MODEM_CONTROL_MASK = 16'h0072;

	// ----------------------------------------
	// modem_status fields (read only)
	// ----------------------------------------
	localparam int CTS_STAT_BIT = 0;
	localparam int DSR_STAT_BIT = 1;
	localparam int RI_STAT_BIT = 2;
	localparam int DCD_STAT_BIT = 3;
	localparam int FLOW_STAT_BIT = 4;
	localparam int RTS_STAT_BIT = 5;

	// ----------------------------------------
	// pin synchroniser
	// ----------------------------------------
	localparam int PIN_COUNT = 6;
	localparam logic [5:0] PIN_IDLE = 6'h3f;

	// modem status lines, active low as on the pins
	typedef struct packed {
		logic dcd_n;
		logic ring_n;
		logic dsr_n;
		logic cts_n;
	} modem_lines_t;

	localparam modem_lines_t LINES_IDLE = 4'hf;

endpackage

// >>> hdl/uart_modem_ctrl_loopback.sv
// modem control, auto flow gating and diagnostic loopback of a serial port
// assumes an apb master on pclk, and transmitter, receiver, fifo and
// infrared coder logic of the port on the same clock
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/100ps

// Operation
// - auto flow control active only with fifos enabled and bit 5 set.
// - loopback in serial mode holds output high, returns tx data inside.
// - interrupt sources keep working unchanged during loopback.
// - loopback ignores modem status pins, feeds own control outputs back.
// - loopback in infrared mode holds ir output low, returns inverted tx.
// - without auto flow, rts_n low when bit 1 set, high when clear.
// - with auto flow, rts_n forced high while rx fifo above threshold.
// - loopback holds rts_n pin high, loops bit 1 to the cts input.
module uart_modem_ctrl_loopback (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic fifo_enable,
	input wire logic rx_above_threshold,
	input wire logic tx_serial,
	input wire logic ir_tx_n,
	input wire logic sin,
	input wire logic sir_in,
	input wire logic clear_to_send_in_n,
	input wire logic data_set_ready_in_n,
	input wire logic ring_indicator_in_n,
	input wire logic carrier_detect_in_n,
	output logic sout,
	output logic sir_out_n,
	output logic request_to_send_n,
	output logic terminal_ready_n,
	output logic user_output_one_n,
	output logic user_output_two_n,
	output logic rx_serial,
	output logic rx_ir,
	output modem_pkg::modem_lines_t modem_lines,
	output logic modem_change,
	output logic auto_flow_mode
);

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	logic [15:0] modem_control_reg;
	logic [15:0] modem_status;
	logic [5:0] pin_raw;
	logic [5:0] pin_clean;

	// zero-wait slave; unmapped offsets answer with an error
	wire sel_control = paddr == modem_pkg::MODEM_CONTROL_OFFSET;
	wire sel_status = paddr == modem_pkg::MODEM_STATUS_OFFSET;
	wire hit = sel_control | sel_status;
	wire setup_rd = psel & ~penable & ~pwrite;
	wire access_wr = psel & penable & pwrite & sel_control;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;

	// read data captured in the setup phase, stable through the access
	wire [31:0] next_prdata = sel_control ? {16'h0000, modem_control_reg} :
		sel_status ? {16'h0000, modem_status} : 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup_rd) begin
			prdata <= next_prdata;
		end
	end

	// ----------------------------------------
	// modem control register
	// ----------------------------------------
	// reserved bits cannot be set, so they always read zero
	wire [15:0] next_control = pwdata[15:0] &
		modem_pkg::MODEM_CONTROL_MASK;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			modem_control_reg <= modem_pkg::MODEM_CONTROL_RESET;
		end else if (access_wr) begin
			modem_control_reg <= next_control;
		end
	end

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	// low four bits in the struct's order: dcd, ring, dsr, cts
	assign pin_raw = {sin, sir_in, carrier_detect_in_n,
		ring_indicator_in_n, data_set_ready_in_n, clear_to_send_in_n};

	// three stages; the clean level moves only when stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < modem_pkg::PIN_COUNT; gi++) begin : g_sync
			logic s1;
			logic s2;
			logic s3;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1 <= modem_pkg::PIN_IDLE[gi];
					s2 <= modem_pkg::PIN_IDLE[gi];
					s3 <= modem_pkg::PIN_IDLE[gi];
					pin_clean[gi] <= modem_pkg::PIN_IDLE[gi];
				end else begin
					s1 <= pin_raw[gi];
					s2 <= s1;
					s3 <= s2;
					if (s2 == s3) begin
						pin_clean[gi] <= s3;
					end
				end
			end
		end
	endgenerate

	wire sin_clean = pin_clean[5];
	wire sir_clean = pin_clean[4];
	modem_pkg::modem_lines_t pin_lines;
	assign pin_lines = pin_clean[3:0];

	// ----------------------------------------
	// mode decode
	// ----------------------------------------
	wire rts_bit = modem_control_reg[modem_pkg::RTS_BIT];
	wire loopback_bit = modem_control_reg[modem_pkg::LOOPBACK_BIT];
	wire auto_flow_enable = modem_control_reg[modem_pkg::AUTO_FLOW_BIT];
	wire ir_mode = modem_control_reg[modem_pkg::IR_MODE_BIT];
	wire serial_loop = loopback_bit & ~ir_mode;
	wire ir_loop = loopback_bit & ir_mode;
	wire next_flow = fifo_enable & auto_flow_enable;

	// ----------------------------------------
	// request-to-send and other control lines
	// ----------------------------------------
	// threshold gating only counts while auto flow is live
	wire rts_gate = next_flow & rx_above_threshold;
	wire rts_internal_n = ~rts_bit | rts_gate;
	// the pin stays idle in loopback so the modem never sees a test
	wire next_rts_n = loopback_bit | rts_internal_n;
	// these outputs have no control bits here and rest inactive
	wire dtr_internal_n = 1'b1;
	wire out1_internal_n = 1'b1;
	wire out2_internal_n = 1'b1;

	// ----------------------------------------
	// serial and infrared paths
	// ----------------------------------------
	wire next_sout = serial_loop | tx_serial;
	wire next_sir_out_n = ~ir_loop & ir_tx_n;
	wire next_rx_serial = serial_loop ? tx_serial : sin_clean;
	wire next_rx_ir = ir_loop ? ~tx_serial : sir_clean;

	// looped lines follow the loopback bit alone, as the ir mode does not
	// change which modem outputs are returned; cts takes the bare rts bit,
	// not the threshold-gated level, so software sees what it wrote
	modem_pkg::modem_lines_t looped_lines;
	assign looped_lines = {out2_internal_n, out1_internal_n, dtr_internal_n,
		~rts_bit};
	modem_pkg::modem_lines_t next_lines;
	assign next_lines = loopback_bit ? looped_lines : pin_lines;

	// ----------------------------------------
	// registered outputs
	// ----------------------------------------
	// one register stage so a write shows on the following clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sout <= 1'b1;
			sir_out_n <= 1'b1;
			request_to_send_n <= 1'b1;
			rx_serial <= 1'b1;
			rx_ir <= 1'b1;
			modem_lines <= modem_pkg::LINES_IDLE;
			auto_flow_mode <= 1'b0;
		end else begin
			sout <= next_sout;
			sir_out_n <= next_sir_out_n;
			request_to_send_n <= next_rts_n;
			rx_serial <= next_rx_serial;
			rx_ir <= next_rx_ir;
			modem_lines <= next_lines;
			auto_flow_mode <= next_flow;
		end
	end

	// fixed-level outputs still come from flops for clean pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			terminal_ready_n <= 1'b1;
			user_output_one_n <= 1'b1;
			user_output_two_n <= 1'b1;
		end else begin
			terminal_ready_n <= dtr_internal_n;
			user_output_one_n <= out1_internal_n;
			user_output_two_n <= out2_internal_n;
		end
	end

	// change pulse feeds the port's interrupt logic in either mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			modem_change <= 1'b0;
		end else begin
			modem_change <= next_lines != modem_lines;
		end
	end

	// ----------------------------------------
	// status word
	// ----------------------------------------
	// lines read active high, as seen by the receiver side
	assign modem_status = {10'h000, ~request_to_send_n, auto_flow_mode,
		~modem_lines.dcd_n, ~modem_lines.ring_n, ~modem_lines.dsr_n,
		~modem_lines.cts_n};

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	flow_enable_a: assert property (
		auto_flow_mode == $past(fifo_enable & auto_flow_enable))
		else $error("auto flow mode not tied to fifo and enable bit");

	serial_loop_a: assert property (
		serial_loop |=> sout && rx_serial == $past(tx_serial))
		else $error("serial loopback output or return wrong");

	loop_change_a: assert property (
		loopback_bit && next_lines != modem_lines |=> modem_change)
		else $error("modem change lost during loopback");

	loop_lines_a: assert property (
		loopback_bit ##1 loopback_bit |-> modem_lines.cts_n ==
		!$past(rts_bit) && modem_lines.dsr_n)
		else $error("looped modem lines wrong");

	pins_ignored_a: assert property (
		loopback_bit |=> modem_lines.dsr_n && modem_lines.ring_n &&
		modem_lines.dcd_n)
		else $error("modem pins leaked into loopback");

	ir_loop_a: assert property (
		ir_loop |=> !sir_out_n && rx_ir == !$past(tx_serial))
		else $error("infrared loopback output or return wrong");

	rts_direct_a: assert property (
		!auto_flow_enable && !loopback_bit |=>
		request_to_send_n == !$past(rts_bit))
		else $error("rts_n does not follow control bit");

	rts_gate_a: assert property (
		next_flow && rx_above_threshold |=> request_to_send_n)
		else $error("rts_n asserted above threshold");

	rts_loop_a: assert property (
		loopback_bit |=> request_to_send_n &&
		modem_lines.cts_n == !$past(rts_bit))
		else $error("rts_n not held idle in loopback");

	write_apply_a: assert property (
		access_wr && !pwdata[modem_pkg::LOOPBACK_BIT] &&
		!pwdata[modem_pkg::AUTO_FLOW_BIT] |-> ##2
		request_to_send_n == !$past(pwdata[modem_pkg::RTS_BIT], 2))
		else $error("written rts value not applied");

	write_reg_a: assert property (
		access_wr |=> modem_control_reg == $past(next_control))
		else $error("control write not stored");

	ctrl_hold_a: assert property (
		!access_wr |=> $stable(modem_control_reg))
		else $error("control register moved without a write");

	sout_normal_a: assert property (
		!serial_loop |=> sout == $past(tx_serial))
		else $error("serial output does not follow tx data");

	ir_normal_a: assert property (
		!ir_loop |=> sir_out_n == $past(ir_tx_n))
		else $error("infrared output does not follow encoder");

	pins_normal_a: assert property (
		!loopback_bit |=> modem_lines == $past(pin_lines) &&
		rx_serial == $past(sin_clean) && rx_ir == $past(sir_clean))
		else $error("pin inputs not passed in normal mode");

	change_pulse_a: assert property (
		modem_change == $changed(modem_lines))
		else $error("modem change pulse does not match line change");

endmodule

// >>> tb/modem_model.sv
// far-side modem model: drives the four status pins, watches rts_n
// assumes the bench clock; pins change just after a rising edge
`timescale 1ns/100ps
module modem_model (
	input wire logic pclk,
	input wire logic rts_n,
	input wire logic [3:0] status_n,
	output logic cts_n = 1'b1,
	output logic dsr_n = 1'b1,
	output logic ring_n = 1'b1,
	output logic dcd_n = 1'b1,
	output logic peer_ready = 1'b0
);
	// line driver registers the wanted status; rts_n low means port ready
	always @(posedge pclk) begin
		{dcd_n, ring_n, dsr_n, cts_n} <= status_n;
		peer_ready <= ~rts_n;
	end
endmodule

// >>> tb/tb.sv
// self-checking bench for the modem-control and loopback block
// assumes zero-wait apb and the modem model on the status pins
`timescale 1ns/100ps
module tb;
	localparam logic [7:0] CTRL = modem_pkg::MODEM_CONTROL_OFFSET;
	localparam logic [7:0] STAT = modem_pkg::MODEM_STATUS_OFFSET;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, err, fifo_enable = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic rx_above_threshold = 1'b0, tx_serial = 1'b1, ir_tx_n = 1'b1;
	logic sin = 1'b1, sir_in = 1'b1, peer_ready, modem_change;
	logic clear_to_send_in_n, data_set_ready_in_n, ring_indicator_in_n;
	logic carrier_detect_in_n, sout, sir_out_n, request_to_send_n;
	logic terminal_ready_n, user_output_one_n, user_output_two_n;
	logic rx_serial, rx_ir, auto_flow_mode;
	logic [3:0] status_n = 4'hf;
	modem_pkg::modem_lines_t modem_lines;
	int mismatches = 0, compares = 0;

	uart_modem_ctrl_loopback DUT (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fifo_enable,
		.rx_above_threshold, .tx_serial, .ir_tx_n, .sin, .sir_in,
		.clear_to_send_in_n, .data_set_ready_in_n, .ring_indicator_in_n,
		.carrier_detect_in_n, .sout, .sir_out_n, .request_to_send_n,
		.terminal_ready_n, .user_output_one_n, .user_output_two_n,
		.rx_serial, .rx_ir, .modem_lines, .modem_change, .auto_flow_mode);
	modem_model peer (.pclk, .rts_n(request_to_send_n), .status_n,
		.cts_n(clear_to_send_in_n), .dsr_n(data_set_ready_in_n),
		.ring_n(ring_indicator_in_n), .dcd_n(carrier_detect_in_n),
		.peer_ready);

	// ----------------------------------------
	// clock, helpers and bus tasks
	// ----------------------------------------
	initial begin
		forever #50 pclk = ~pclk;
	end

	task automatic tick(int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	// setup then access; holds everything until pready is seen high
	task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge, so a following call never sets psel in the same step
		@(posedge pclk);
	endtask

	task automatic wr(logic [31:0] d);
		apb(1'b1, CTRL, d);
	endtask

	task automatic give_verdict;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// whole run is under a hundred cycles; this only cuts a hang
	initial begin
		tick(3000);
		mismatches++;
		give_verdict();
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		tick(16);
		presetn <= 1'b1;
		tick(1);
		apb(1'b0, CTRL, 32'h0000_0000);
		chk("ctrl reset", {16'h0000, modem_pkg::MODEM_CONTROL_RESET}, rd);
		chk("pins idle", 6'h3f, {sout, sir_out_n, request_to_send_n,
			terminal_ready_n, user_output_one_n, user_output_two_n});
		wr(32'hffff_ffff);
		apb(1'b0, CTRL, 32'h0000_0000);
		chk("ctrl mask", 32'h0000_0072, rd);
		apb(1'b1, 8'h14, 32'h0000_0002);
		chk("unmapped err", 1'b1, err);
		apb(1'b0, 8'h14, 32'h0000_0000);
		chk("unmapped data", 32'h0000_0000, rd);
		wr(32'h0000_0000);
		$display("end of test registers");
		// direct rts: wr returns on the edge after the write edge, the
		// one that launches the new level, so the old level is still seen
		wr(32'h0000_0002);
		chk("rts early", 1'b1, request_to_send_n);
		tick(1);
		chk("rts on", 1'b0, request_to_send_n);
		tick(1);
		chk("peer ready", 1'b1, peer_ready);
		$display("end of test direct_rts");
		fifo_enable <= 1'b1;
		rx_above_threshold <= 1'b1;
		wr(32'h0000_0022);
		tick(2);
		chk("auto on", 1'b1, auto_flow_mode);
		chk("rts gated", 1'b1, request_to_send_n);
		rx_above_threshold <= 1'b0;
		tick(2);
		chk("rts below", 1'b0, request_to_send_n);
		fifo_enable <= 1'b0;
		rx_above_threshold <= 1'b1;
		tick(2);
		chk("auto off", 1'b0, auto_flow_mode);
		chk("rts no fifo", 1'b0, request_to_send_n);
		$display("end of test auto_flow");
		rx_above_threshold <= 1'b0;
		// alternating levels so a swap of two neighbouring status pins shows up
		status_n <= 4'h5;
		sin <= 1'b0;
		sir_in <= 1'b0;
		tick(7);
		chk("change pulse", 1'b1, modem_change);
		tick(1);
		chk("change ends", 1'b0, modem_change);
		chk("lines normal", 4'h5, modem_lines);
		chk("rx from pin", 1'b0, rx_serial);
		chk("ir from pin", 1'b0, rx_ir);
		wr(32'h0000_0012);
		tick(1);
		chk("change loop", 1'b1, modem_change);
		tick(1);
		chk("sout held", 1'b1, sout);
		chk("rts held", 1'b1, request_to_send_n);
		chk("lines looped", 4'he, modem_lines);
		chk("rx looped", 1'b1, rx_serial);
		apb(1'b0, STAT, 32'h0000_0000);
		chk("status looped", 32'h0000_0001, rd);
		tx_serial <= 1'b0;
		tick(2);
		chk("rx follows", 1'b0, rx_serial);
		chk("sout still", 1'b1, sout);
		wr(32'h0000_0010);
		tick(2);
		chk("lines rts off", 4'hf, modem_lines);
		$display("end of test serial_loopback");
		wr(32'h0000_0050);
		tick(2);
		chk("ir out held", 1'b0, sir_out_n);
		chk("ir inverted", 1'b1, rx_ir);
		tx_serial <= 1'b1;
		tick(2);
		chk("ir inv high", 1'b0, rx_ir);
		$display("end of test ir_loopback");
		give_verdict();
	end
endmodule
